//--- rtl/lcd_pkg.sv
// shared constants and types of the segment lcd controller
package lcd_pkg;
  // clock and refresh limits
  localparam int unsigned CLK_HZ       = 50_000_000;
  localparam int unsigned REFRESH_MIN  = 10;    // Hz
  localparam int unsigned REFRESH_MAX  = 150;   // Hz
  localparam int unsigned MAX_COMMONS  = 16;
  localparam int unsigned SLOT_PHASES  = 2;     // phase ticks per common in the standard wave
  // least phase period: fastest frame with every common, rounded up
  localparam int unsigned PHASE_MIN_CYC =
    (CLK_HZ + REFRESH_MAX * MAX_COMMONS * SLOT_PHASES - 1) /
    (REFRESH_MAX * MAX_COMMONS * SLOT_PHASES);
  // longest phase period: slowest frame with one common, rounded down
  localparam int unsigned PHASE_MAX_CYC = CLK_HZ / (REFRESH_MIN * SLOT_PHASES);
  localparam int unsigned PHASE_W       = 22;

  // register byte offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_PHASE  = 8'h04;
  localparam logic [7:0] OFS_ROLE0  = 8'h08;
  localparam logic [7:0] OFS_ROLE1  = 8'h0C;
  localparam logic [7:0] OFS_DATA   = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;

  // control register fields
  localparam int unsigned CTRL_EN      = 0;
  localparam int unsigned CTRL_WAVE_B  = 1;
  localparam int unsigned CTRL_INVERT  = 2;
  localparam int unsigned CTRL_BIAS    = 4;   // 3 bits
  localparam int unsigned CTRL_NCOM    = 8;   // 4 bits, commons minus one
  localparam int unsigned CTRL_DRIVE   = 12;  // 2 bits
  localparam int unsigned CTRL_CONTR   = 16;  // 6 bits
  localparam logic [31:0] CTRL_RESET   = 32'h0000_0000;
  localparam logic [21:0] PHASE_RESET  = 22'h00_28B1; // 10417 cycles

  // status register fields
  localparam int unsigned ST_POL     = 4;
  localparam int unsigned ST_UNDER   = 5;
  localparam int unsigned ST_REQ     = 6;
  localparam int unsigned ST_EMPTY   = 7;

  // bias codes
  localparam logic [2:0] BIAS_STATIC = 3'h0;
  localparam logic [2:0] BIAS_FIFTH  = 3'h4;
  localparam logic [1:0] DRIVE_MAX   = 2'h2;

  typedef enum logic [1:0] {FETCH_LO, FETCH_HI, FETCH_DONE} fetch_t;
endpackage

//--- rtl/lcd_segment_drive_control.sv
// segment lcd scan controller with wishbone registers and display data fifo
//
// The implementer's own choices: the Wishbone slave port and the placing of the registers.
`timescale 1ns/100ps
module lcd_segment_drive_control
  import lcd_pkg::*;
#(
  parameter int N_PINS    = 62,
  parameter int FIFO_DEPTH = 4,
  parameter int unsigned PHASE_MIN = PHASE_MIN_CYC,
  parameter int unsigned PHASE_MAX = PHASE_MAX_CYC
) (
  // clock and reset
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  // wishbone slave
  input  wire logic                  cyc_i,
  input  wire logic                  stb_i,
  input  wire logic                  we_i,
  input  wire logic [7:0]            adr_i,
  input  wire logic [3:0]            sel_i,
  input  wire logic [31:0]           dat_i,
  output logic      [31:0]           dat_o,
  output logic                       ack_o,
  // dma request
  output logic                       dma_req_o,
  // global lcd control
  output logic [3:0]                 com_slot_o,
  output logic                       polarity_o,
  output logic [2:0]                 bias_o,
  output logic [5:0]                 contrast_o,
  output logic [1:0]                 drive_mode_o,
  // per-pin bias level select, three bits per pin
  output logic [3*N_PINS-1:0]        pin_level_o
);
  ////////////////////////////////////////////////////////////////////////////
  // level choice for one pin
  function automatic logic [2:0] level_sel(input logic is_com, input logic on,
                                           input logic pol, input logic [2:0] bias);
    logic [2:0] top;
    logic [2:0] r;
    top = bias + 3'h1;   // highest level index
    r   = '0;
    if (is_com) begin
      if (on || bias == BIAS_STATIC) begin
        r = pol ? top : 3'h0;
      end else begin
        r = pol ? 3'h1 : top - 3'h1;
      end
    end else if (on) begin
      r = pol ? 3'h0 : top;
    end else if (top <= 3'h2) begin
      r = pol ? top : 3'h0;
    end else begin
      r = pol ? top - 3'h2 : 3'h2;
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // fifo between the data register and the scan logic
  stream_if #(.W(32)) fin ();
  stream_if #(.W(32)) fout ();

  word_fifo #(.WIDTH(32), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .wr    (fin),
    .rd    (fout)
  );

  ////////////////////////////////////////////////////////////////////////////
  // register state
  logic [31:0]       ctrl, next_ctrl;
  logic [PHASE_W-1:0] phase_len, next_phase_len;
  logic [63:0]       role, next_role;
  logic              under, next_under;
  logic              ack, next_ack;
  logic [31:0]       rdata, next_rdata;

  // scan state
  logic [PHASE_W-1:0] tick_cnt, next_tick_cnt;
  logic [3:0]        slot, next_slot;
  logic              pol, next_pol;
  logic              half, next_half;
  logic [5:0]        owed, next_owed;
  logic              en_d, next_en_d;
  fetch_t            fetch, next_fetch;
  logic [63:0]       shadow, next_shadow;
  logic [63:0]       cur, next_cur;
  logic [3*N_PINS-1:0] level, next_level;

  logic              en, wave_b, invert;
  logic [2:0]        bias_q;
  logic [3:0]        ncom_m1;
  logic [PHASE_W-1:0] phase_eff;
  logic              req, wr_go, tick, slot_step, frame_wrap, frame_start;

  assign en      = ctrl[CTRL_EN];
  assign wave_b  = ctrl[CTRL_WAVE_B];
  assign invert  = ctrl[CTRL_INVERT];
  assign ncom_m1 = ctrl[CTRL_NCOM+:4];

  // bias codes above one-fifth act as one-fifth
  assign bias_q = (ctrl[CTRL_BIAS+:3] > BIAS_FIFTH) ? BIAS_FIFTH : ctrl[CTRL_BIAS+:3];

  // phase period clamped into the refresh range
  always_comb begin
    phase_eff = phase_len;
    if (phase_len < PHASE_W'(PHASE_MIN)) begin
      phase_eff = PHASE_W'(PHASE_MIN);
    end else if (phase_len > PHASE_W'(PHASE_MAX)) begin
      phase_eff = PHASE_W'(PHASE_MAX);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // wishbone decode
  assign req   = cyc_i & stb_i;
  assign wr_go = req & we_i & ack;   // write commits at the acked edge

  // data writes feed the fifo
  assign fin.valid = wr_go & (adr_i == OFS_DATA);
  assign fin.data  = dat_i;

  // read mux
  function automatic logic [31:0] rd_mux(input logic [7:0] a, input logic [31:0] c,
                                         input logic [PHASE_W-1:0] p, input logic [63:0] r,
                                         input logic [31:0] st);
    logic [31:0] v;
    v = '0;
    case (a)
      OFS_CTRL:   v = c;
      OFS_PHASE:  v = {{(32-PHASE_W){1'b0}}, p};
      OFS_ROLE0:  v = r[31:0];
      OFS_ROLE1:  v = r[63:32];
      OFS_STATUS: v = st;
      default:    v = '0;
    endcase
    return v;
  endfunction

  logic [31:0] status;
  always_comb begin
    status            = '0;
    status[3:0]       = slot;
    status[ST_POL]    = pol;
    status[ST_UNDER]  = under;
    status[ST_REQ]    = dma_req_o;
    status[ST_EMPTY]  = ~fout.valid;
  end

  // byte-lane merge of a written word
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] s);
    logic [31:0] v;
    v = old;
    for (int b = 0; b < 4; b++) begin
      if (s[b]) begin
        v[8*b+:8] = d[8*b+:8];
      end
    end
    return v;
  endfunction

  // register next values
  always_comb begin
    next_ctrl      = ctrl;
    next_phase_len = phase_len;
    next_role      = role;
    next_rdata     = rdata;
    next_ack       = 1'b0;
    // data writes wait while the fifo is full
    if (req && !ack && (!we_i || adr_i != OFS_DATA || fin.ready)) begin
      next_ack   = 1'b1;
      next_rdata = we_i ? 32'h0000_0000 : rd_mux(adr_i, ctrl, phase_len, role, status);
    end
    if (wr_go) begin
      case (adr_i)
        OFS_CTRL:  next_ctrl = merge(ctrl, dat_i, sel_i) & 32'h003F_3FF7;
        OFS_PHASE: next_phase_len = PHASE_W'(merge({{(32-PHASE_W){1'b0}}, phase_len},
                                                   dat_i, sel_i));
        OFS_ROLE0: next_role[31:0]  = merge(role[31:0], dat_i, sel_i);
        OFS_ROLE1: next_role[63:32] = merge(role[63:32], dat_i, sel_i);
        default:   next_ctrl = ctrl;
      endcase
    end
    next_role[63:N_PINS] = '0;   // pins beyond the driver count
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl      <= CTRL_RESET;
      phase_len <= PHASE_RESET;
      role      <= '0;
      rdata     <= '0;
      ack       <= 1'b0;
    end else begin
      ctrl      <= next_ctrl;
      phase_len <= next_phase_len;
      role      <= next_role;
      rdata     <= next_rdata;
      ack       <= next_ack;
    end
  end

  assign ack_o = ack;
  assign dat_o = rdata;

  ////////////////////////////////////////////////////////////////////////////
  // timing generator: phase ticks, slot counter, polarity
  assign tick        = en & (tick_cnt == '0);
  assign slot_step   = tick & (wave_b | half);
  assign frame_wrap  = slot_step & (slot == ncom_m1);
  assign frame_start = (en & ~en_d) | frame_wrap;

  always_comb begin
    next_tick_cnt = tick_cnt;
    next_slot     = slot;
    next_pol      = pol;
    next_half     = half;
    next_en_d     = en;
    if (!en) begin
      next_tick_cnt = phase_eff - 1'b1;
      next_slot     = '0;
      next_pol      = 1'b0;
      next_half     = 1'b0;
    end else if (tick) begin
      next_tick_cnt = phase_eff - 1'b1;
      if (!wave_b) begin
        next_half = ~half;
        next_pol  = ~pol;
      end else if (frame_wrap) begin
        next_pol  = ~pol;
      end
      if (slot_step) begin
        next_slot = frame_wrap ? 4'h0 : slot + 4'h1;
      end
    end else begin
      next_tick_cnt = tick_cnt - 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tick_cnt <= '0;
      slot     <= '0;
      pol      <= 1'b0;
      half     <= 1'b0;
      en_d     <= 1'b0;
    end else begin
      tick_cnt <= next_tick_cnt;
      slot     <= next_slot;
      pol      <= next_pol;
      half     <= next_half;
      en_d     <= next_en_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // dma request: words owed for the coming frame, two per common
  assign dma_req_o = en & (owed != '0) & fin.ready;

  // data fetch: two fifo words make one slot of pin data
  assign fout.ready = en & (fetch != FETCH_DONE);

  always_comb begin
    next_owed   = owed;
    next_fetch  = fetch;
    next_shadow = shadow;
    next_cur    = cur;
    next_under  = under;
    if (fin.valid && owed != '0) begin
      next_owed = owed - 6'h1;
    end
    if (frame_start) begin
      next_owed = {1'b0, ncom_m1, 1'b0} + 6'h2;
    end
    case (fetch)
      FETCH_LO: begin
        if (fout.valid && fout.ready) begin
          next_shadow[31:0] = fout.data;
          next_fetch        = FETCH_HI;
        end
      end
      FETCH_HI: begin
        if (fout.valid && fout.ready) begin
          next_shadow[63:32] = fout.data;
          next_fetch         = FETCH_DONE;
        end
      end
      default: next_fetch = fetch;
    endcase
    // write one clears the underrun flag
    if (wr_go && adr_i == OFS_STATUS && sel_i[0] && dat_i[ST_UNDER]) begin
      next_under = 1'b0;
    end
    // new slot takes the prefetched data into the pin data register
    if (slot_step) begin
      if (fetch == FETCH_DONE) begin
        next_cur   = shadow;
        next_fetch = FETCH_LO;
      end else begin
        next_under = 1'b1;      // data late, old data held; set wins
      end
    end
    if (!en) begin
      next_fetch = FETCH_LO;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      owed   <= '0;
      fetch  <= FETCH_LO;
      shadow <= '0;
      cur    <= '0;
      under  <= 1'b0;
    end else begin
      owed   <= next_owed;
      fetch  <= next_fetch;
      shadow <= next_shadow;
      cur    <= next_cur;
      under  <= next_under;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // per-pin level select, segments inverted on request
  for (genvar i = 0; i < N_PINS; i++) begin : g_pin
    always_comb begin
      next_level[3*i+:3] = en ? level_sel(role[i], cur[i] ^ (invert & ~role[i]),
                                          pol, bias_q) : 3'h0;
    end
  end

  // registered pin outputs; global outputs taken from the control and scan registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      level <= '0;
    end else begin
      level <= next_level;
    end
  end

  assign pin_level_o  = level;
  assign com_slot_o   = slot;
  assign polarity_o   = pol;
  assign bias_o       = bias_q;
  assign contrast_o   = ctrl[CTRL_CONTR+:6];
  // drive mode code three acts as the strongest mode
  assign drive_mode_o = (ctrl[CTRL_DRIVE+:2] > DRIVE_MAX) ? DRIVE_MAX
                                                          : ctrl[CTRL_DRIVE+:2];
endmodule

//--- rtl/stream_if.sv
// valid/ready word stream between the controller and its fifo
`timescale 1ns/100ps
interface stream_if #(parameter int W = 32);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

//--- rtl/word_fifo.sv
// small first-in first-out word buffer
`timescale 1ns/100ps
module word_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 4
) (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // streams
  stream_if.snk     wr,
  stream_if.src     rd
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr, next_wr_ptr;
  logic [AW-1:0]    rd_ptr, next_rd_ptr;
  logic [AW:0]      count, next_count;
  logic             push, pop;

  ////////////////////////////////////////////////////////////////////////////
  // handshakes
  assign wr.ready = (count != AW'(0) + (AW+1)'(DEPTH)) ? 1'b1 : 1'b0;
  assign rd.valid = (count != '0);
  assign rd.data  = mem[rd_ptr];
  assign push     = wr.valid & wr.ready;
  assign pop      = rd.valid & rd.ready;

  // pointer and fill next values
  always_comb begin
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    next_count  = count;
    if (push) begin
      next_wr_ptr = (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
    end
    if (pop) begin
      next_rd_ptr = (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
    end
    if (push && !pop) begin
      next_count = count + 1'b1;
    end else if (pop && !push) begin
      next_count = count - 1'b1;
    end
  end

  // state registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count  <= next_count;
    end
  end

  // storage, written only on push
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wr_ptr] <= wr.data;
    end
  end
endmodule

//--- verif/lcd_glass_model.sv
// glass panel model: segments that see full swing against a common
`timescale 1ns/100ps
module lcd_glass_model #(
  parameter int N = 62
) (
  // electrode drive
  input  wire logic [3*N-1:0] level_i,
  input  wire logic [N-1:0]   role_i,
  input  wire logic [2:0]     bias_i,
  // lit segments
  output logic      [N-1:0]   lit_o
);
  logic [2:0] top;

  // a pixel lights only at the full bias swing
  always_comb begin
    top = (bias_i > 3'h4) ? 3'h5 : bias_i + 3'h1;
    lit_o = '0;
    for (int s = 0; s < N; s++)
      for (int c = 0; c < N; c++)
        if (!role_i[s] && role_i[c] &&
            ((level_i[3*c+:3] === top && level_i[3*s+:3] === 3'h0) ||
             (level_i[3*c+:3] === 3'h0 && level_i[3*s+:3] === top)))
          lit_o[s] = 1'b1;
  end
endmodule

//--- verif/lcd_segment_drive_control_bench.sv
// self-checking bench for the segment lcd controller
`timescale 1ns/100ps
module lcd_segment_drive_control_bench
  import lcd_pkg::*;
;
  localparam int N = 62;
  logic           clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, dma_req_o, polarity_o;
  logic [7:0]     adr_i;
  logic [3:0]     sel_i, com_slot_o, slot_q;
  logic [31:0]    dat_i, dat_o;
  logic [2:0]     bias_o;
  logic [5:0]     contrast_o;
  logic [1:0]     drive_mode_o;
  logic [3*N-1:0] pin_level_o;
  logic [N-1:0]   lit;
  logic [63:0]    per;
  logic           seen, chk, run_on;
  int             errors, total_checks, cycles, seed, gap;
  logic [31:0]    rdq[$];
  logic [N-1:0]   pxq[$];

  lcd_segment_drive_control #(.PHASE_MIN(16), .PHASE_MAX(48)) i_dut (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
    .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .dma_req_o(dma_req_o),
    .com_slot_o(com_slot_o), .polarity_o(polarity_o), .bias_o(bias_o),
    .contrast_o(contrast_o), .drive_mode_o(drive_mode_o), .pin_level_o(pin_level_o));
  lcd_glass_model #(.N(N)) i_glass (
    .level_i(pin_level_o), .role_i(62'h3), .bias_i(bias_o), .lit_o(lit));

  // 50 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  ////////////////////////////////////////
  task automatic finish_test;
    if (errors == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic check(input string nm, input logic [63:0] s, input logic [63:0] e);
    total_checks++;
    if (s !== e) begin
      errors++;
      $display("BAD %s exp %h seen %h", nm, e, s);
    end
  endtask

  // classic wishbone cycle, expectation noted for the monitor
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] s, input logic [31:0] e);
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    sel_i <= s;
    dat_i <= d;
    rdq.push_back(w ? 32'h0 : e);
    @(posedge clk_i);
    while (ack_o !== 1'b1) @(posedge clk_i);
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask

  // one display run: two commons, four word pairs through the fifo
  task automatic run(input logic lp, input logic inv, input logic [2:0] b,
                     input logic [31:0] ph, input logic [63:0] pv);
    logic [31:0] lo, hi, c;
    bus(1'b1, OFS_PHASE, ph, 4'hF, 32'h0);
    c = 32'h0;
    c[CTRL_EN] = 1'b1;
    c[CTRL_WAVE_B] = lp;
    c[CTRL_INVERT] = inv;
    c[CTRL_BIAS+:3] = b;
    c[CTRL_NCOM+:4] = 4'h1;
    per = pv;
    seen = 1'b0;
    run_on = 1'b1;
    bus(1'b1, OFS_CTRL, c, 4'hF, 32'h0);
    while (dma_req_o !== 1'b1) @(posedge clk_i);
    for (int w = 0; w < 4; w++) begin
      lo = $random(seed);
      hi = $random(seed);
      lo[1:0] = w[0] ? 2'h2 : 2'h1;
      pxq.push_back(({hi[29:0], lo} ^ {N{inv}}) & ~62'h3);
      bus(1'b1, OFS_DATA, lo, 4'hF, 32'h0);
      bus(1'b1, OFS_DATA, hi, 4'hF, 32'h0);
    end
    while (pxq.size() > 0) @(posedge clk_i);
    run_on = 1'b0;
    bus(1'b1, OFS_CTRL, 32'h0, 4'hF, 32'h0);
    @(posedge clk_i);
    check("dma request", dma_req_o, 1'b0);
  endtask

  ////////////////////////////////////////
  // read data against the oldest note
  always @(posedge clk_i)
    if (ack_o === 1'b1 && rdq.size() > 0) check("read data", dat_o, rdq.pop_front());

  // pixels and slot period after each slot step
  always @(posedge clk_i) begin
    gap++;
    if (chk && pxq.size() > 0) check("pixels", lit, pxq.pop_front());
    chk = 1'b0;
    if (run_on && com_slot_o !== slot_q) begin
      if (seen) check("slot period", gap, per);
      seen = 1'b1;
      gap = 0;
      chk = 1'b1;
    end
    slot_q = com_slot_o;
  end

  // hang guard
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      finish_test;
    end
  end

  // main sequence
  initial begin
    logic [31:0] r, v;
    seed = 9314;
    errors = 0;
    total_checks = 0;
    cycles = 0;
    gap = 0;
    per = 64'h0;
    seen = 1'b0;
    chk = 1'b0;
    run_on = 1'b0;
    slot_q = 4'h0;
    rst_i = 1'b1;
    cyc_i = 1'b0;
    stb_i = 1'b0;
    we_i = 1'b0;
    adr_i = 8'h00;
    sel_i = 4'h0;
    dat_i = 32'h0;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    bus(1'b0, OFS_CTRL, 32'h0, 4'hF, CTRL_RESET);
    bus(1'b0, OFS_PHASE, 32'h0, 4'hF, {10'h000, PHASE_RESET});
    bus(1'b0, OFS_STATUS, 32'h0, 4'hF, 32'h0000_0080);
    r = $random(seed);
    bus(1'b1, OFS_ROLE0, r, 4'hF, 32'h0);
    bus(1'b1, OFS_ROLE0, ~r, 4'h3, 32'h0);
    bus(1'b0, OFS_ROLE0, 32'h0, 4'hF, {r[31:16], ~r[15:0]});
    bus(1'b1, OFS_ROLE1, {2'h0, r[29:0]}, 4'hF, 32'h0);
    bus(1'b0, OFS_ROLE1, 32'h0, 4'hF, {2'h0, r[29:0]});
    bus(1'b1, 8'h20, r, 4'hF, 32'h0);
    bus(1'b0, 8'h20, 32'h0, 4'hF, 32'h0);
    bus(1'b0, OFS_DATA, 32'h0, 4'hF, 32'h0);
    // every bias code and drive mode
    for (int i = 0; i < 8; i++) begin
      r = $random(seed);
      v = 32'h0;
      v[CTRL_BIAS+:3] = i[2:0];
      v[CTRL_DRIVE+:2] = 2'(i % 4);
      v[CTRL_CONTR+:6] = r[5:0];
      bus(1'b1, OFS_CTRL, v, 4'hF, 32'h0);
      bus(1'b0, OFS_CTRL, 32'h0, 4'hF, v);
      check("bias", bias_o, (i > 4) ? BIAS_FIFTH : v[6:4]);
      check("drive", drive_mode_o, (i % 4 == 3) ? 2'h2 : v[13:12]);
      check("contrast", contrast_o, v[21:16]);
    end
    bus(1'b1, OFS_ROLE0, 32'h3, 4'hF, 32'h0);
    bus(1'b1, OFS_ROLE1, 32'h0, 4'hF, 32'h0);
    run(1'b0, 1'b0, 3'h2, 32'd20, 64'd40);
    run(1'b1, 1'b1, 3'h3, 32'd1000, 64'd48);
    run(1'b0, 1'b1, 3'h4, 32'd1, 64'd32);
    // slot step with no data sets underrun, write one clears it
    bus(1'b1, OFS_CTRL, 32'h1, 4'hF, 32'h0);
    repeat (40) @(posedge clk_i);
    bus(1'b1, OFS_CTRL, 32'h0, 4'hF, 32'h0);
    bus(1'b0, OFS_STATUS, 32'h0, 4'hF, 32'h0000_00A0);
    bus(1'b1, OFS_STATUS, 32'h20, 4'h1, 32'h0);
    bus(1'b0, OFS_STATUS, 32'h0, 4'hF, 32'h0000_0080);
    finish_test;
  end
endmodule

//--- verif/lcd_segment_drive_control_sva.sv
// port assertions for the segment lcd controller
`timescale 1ns/100ps
module lcd_drive_checker
  import lcd_pkg::*;
#(
  parameter int N_PINS = 62
) (
  // clock and reset
  input wire logic                clk_i,
  input wire logic                rst_i,
  // wishbone
  input wire logic                cyc_i,
  input wire logic                stb_i,
  input wire logic                we_i,
  input wire logic [7:0]          adr_i,
  input wire logic [3:0]          sel_i,
  input wire logic [31:0]         dat_i,
  input wire logic [31:0]         dat_o,
  input wire logic                ack_o,
  // scan side
  input wire logic                dma_req_o,
  input wire logic [3:0]          com_slot_o,
  input wire logic                polarity_o,
  input wire logic [5:0]          contrast_o,
  input wire logic [3*N_PINS-1:0] pin_level_o
);
  logic       wr;
  logic       wr_q;
  logic       en_q;
  logic       lvl_bad;
  logic [5:0] contr_q;

  // control writes as the slave commits them
  assign wr = cyc_i && stb_i && we_i && ack_o && adr_i == OFS_CTRL;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wr_q <= 1'b0;
      en_q <= 1'b0;
      contr_q <= 6'h00;
    end else begin
      wr_q <= wr && sel_i[2];
      contr_q <= dat_i[CTRL_CONTR+:6];
      if (wr && sel_i[0]) en_q <= dat_i[CTRL_EN];
    end
  end

  // any pin beyond the six levels
  always_comb begin
    lvl_bad = 1'b0;
    for (int i = 0; i < N_PINS; i++)
      if (pin_level_o[3*i+:3] > 3'h5) lvl_bad = 1'b1;
  end

  ////////////////////////////////////////
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  ack_pulse_a: assert property (ack_o |=> !ack_o)
    else $error("ack longer than one cycle");
  ack_cause_a: assert property (!(cyc_i && stb_i) |=> !ack_o)
    else $error("ack without request");
  ack_answer_a: assert property ((cyc_i && stb_i && !ack_o && adr_i != OFS_DATA) |=> ack_o)
    else $error("register request not answered next cycle");
  wr_zero_a: assert property (ack_o && we_i |-> dat_o == 32'h0)
    else $error("read data not zero on write");
  reset_vals_a: assert property ($past(rst_i) |-> !dma_req_o && com_slot_o == 4'h0 &&
    !polarity_o && pin_level_o == '0 && contrast_o == 6'h00)
    else $error("outputs not at reset values");
  slot_step_a: assert property ($changed(com_slot_o) |->
    com_slot_o == $past(com_slot_o) + 4'h1 || com_slot_o == 4'h0)
    else $error("common slot skipped");
  wrap_pol_a: assert property (en_q && $changed(com_slot_o) && com_slot_o == 4'h0
    |-> $changed(polarity_o))
    else $error("polarity kept across frame wrap");
  level_range_a: assert property (!lvl_bad)
    else $error("pin level beyond six levels");
  contrast_set_a: assert property (wr_q |-> contrast_o == contr_q)
    else $error("contrast not taken from write");
  contrast_hold_a: assert property ($changed(contrast_o) |-> wr_q)
    else $error("contrast changed without write");
  dma_idle_a: assert property (!en_q |-> !dma_req_o)
    else $error("dma request while disabled");
  idle_levels_a: assert property (!en_q && !$past(en_q) |-> pin_level_o == '0)
    else $error("pin levels driven while disabled");
endmodule

bind lcd_segment_drive_control lcd_drive_checker #(.N_PINS(N_PINS)) i_chk (
  .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
  .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .dma_req_o(dma_req_o),
  .com_slot_o(com_slot_o), .polarity_o(polarity_o), .contrast_o(contrast_o),
  .pin_level_o(pin_level_o)
);
